/* hw/dhi_device.sv */
// display host port, device end: decodes the strapped bus style into a byte stream
`timescale 1ns/100ps
`default_nettype none
`include "dhi_params.svh"
// What this block does
// - straps pick bus style; kept static
// - chip select is active low
// - init low holds settings at initial values
// - select high: byte is display data
// - select low: byte goes to commands
// - I2C: select pin is address bit
// - separate strobes: capture on write rising
// - enable style: direction pin, high reads
// - separate strobes: drive bus only during read low
// - enable style: read pin is enable clock
// - eight-bit two-way parallel data bus
// - serial: line0 clock, line1 data, rest released
// - I2C: line0 clock, line1 data, rest released
module dhi_device
    import dhi_pkg::*;
(
    input  wire logic       clk_sys_in,      // 40 MHz system clock
    input  wire logic       rst_in,          // synchronous reset, active high
    input  wire logic       ce_in,           // clock enable, freezes all state
    dhi_if.device           pin,             // host-facing pins
    input  wire logic [7:0] rd_byte_in,      // byte returned on parallel reads
    output logic            rd_strobe_out,   // pulse at start of a parallel read
    output logic            m_valid_out,     // received byte available
    input  wire logic       m_ready_in,      // consumer takes byte
    output logic [7:0]      m_byte_out,      // received byte
    output logic            m_is_data_out,   // 1 display data, 0 command
    output logic            init_active_out, // settings held at initial values
    output logic            ovf_out          // sticky: byte lost on full buffer
);
    localparam int SW = 16;

    // every pin crosses two flops before any logic looks at it
    logic [SW-1:0] s1_ff;
    logic [SW-1:0] s2_ff;
    wire  [SW-1:0] pins_raw = {pin.strap, pin.cs_n, pin.init_n, pin.dc,
                               pin.wr_n, pin.rd_n, pin.bus};

    always_ff @(posedge clk_sys_in) begin
        if (ce_in) begin
            s1_ff <= pins_raw;
            s2_ff <= s1_ff;
        end
    end

    wire [2:0] strap_s = s2_ff[15:13];
    wire       cs_n_s  = s2_ff[12];
    wire       init_s  = s2_ff[11];
    wire       dc_s    = s2_ff[10];
    wire       wr_s    = s2_ff[9];
    wire       rd_s    = s2_ff[8];
    wire [7:0] d_s     = s2_ff[7:0];

    dhi_mode_e  mode_ff;
    dhi_i2c_e   i2c_ff;
    logic [3:0] pv_ff;
    logic [7:0] sh_ff;
    logic [3:0] cnt_ff;
    logic       i2c_dc_ff;
    logic       i2c_cont_ff;
    logic       ack_ff;
    logic [7:0] oe_ff;
    logic [7:0] vd_ff;
    logic       ovf_ff;
    logic       init_ff;
    logic       rd_stb_ff;
    logic       pv_sda_ff;

    wire clr = rst_in || !init_s;
    wire sel = !cs_n_s;

    wire m_sep = (mode_ff == MODE_SEP);
    wire m_ena = (mode_ff == MODE_ENA);
    wire m_spi = (mode_ff == MODE_SPI);
    wire m_i2c = (mode_ff == MODE_I2C);

    // edges, all qualified by chip select
    wire wr_rise  = sel && wr_s && !pv_ff[3];
    wire en_fall  = sel && !rd_s && pv_ff[2];
    wire ck_rise  = sel && d_s[0] && !pv_ff[1];
    wire ck_fall  = sel && !d_s[0] && pv_ff[0];
    // start and stop need the data line's own history, not the clock's
    wire sda_fall = sel && d_s[0] && pv_ff[0] && !d_s[1] && pv_sda_ff;
    wire sda_rise = sel && d_s[0] && pv_ff[0] && d_s[1] && !pv_sda_ff;

    wire sep_wr = m_sep && wr_rise;
    wire ena_wr = m_ena && en_fall && !wr_s;
    wire spi_wr = m_spi && ck_rise && (cnt_ff == `DHI_SPI_LAST);

    // i2c byte boundary: falling clock after the eighth rising clock of a byte (bit counter at 8)
    wire i2c_start = m_i2c && sda_fall;
    wire i2c_stop  = m_i2c && sda_rise;
    wire i2c_byte  = m_i2c && ck_fall && (cnt_ff == `DHI_I2C_ACK_CNT);
    wire i2c_end   = m_i2c && ck_fall && (cnt_ff == `DHI_I2C_END_CNT);
    wire addr_hit  = (sh_ff[7:1] == {`DHI_I2C_ADDR_HI, dc_s}) && !sh_ff[0];
    wire i2c_wr    = i2c_byte && (i2c_ff == I2_DATA);

    wire       fifo_ready;
    wire       push_v  = sep_wr || ena_wr || spi_wr || i2c_wr;
    wire [7:0] spi_b   = {sh_ff[6:0], d_s[1]};
    wire [7:0] push_b  = m_i2c ? sh_ff : (m_spi ? spi_b : d_s);
    wire       push_dc = m_i2c ? i2c_dc_ff : dc_s;

    // only i2c can refuse a byte (no acknowledge); other styles lose it
    wire i2c_ack = (i2c_ff == I2_ADDR) ? addr_hit :
                   (i2c_ff == I2_CTRL) ? 1'b1 :
                   (i2c_ff == I2_DATA) ? fifo_ready : 1'b0;

    wire rd_act = sel && ((m_sep && !rd_s) || (m_ena && rd_s && wr_s));
    wire [7:0] nxt_oe = rd_act ? 8'hff : {6'h00, ack_ff, 1'b0};
    wire [7:0] nxt_vd = rd_act ? rd_byte_in : 8'h00;

    // straps are caught while reset is held and kept until the next reset
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mode_ff <= dhi_mode_of(strap_s);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pv_ff     <= 4'hf;
            pv_sda_ff <= 1'b1;
        end else if (ce_in) begin
            pv_ff     <= {wr_s, rd_s, d_s[0], d_s[0]};
            pv_sda_ff <= d_s[1];
        end
    end

    // shift register and bit counter, shared by both serial styles
    always_ff @(posedge clk_sys_in) begin
        if (clr || !sel) begin
            sh_ff  <= 8'h00;
            cnt_ff <= 4'h0;
        end else if (ce_in) begin
            if (m_spi && ck_rise) begin
                sh_ff  <= spi_b;
                cnt_ff <= (cnt_ff == `DHI_SPI_LAST) ? 4'h0 : cnt_ff + 4'h1;
            end else if (i2c_start) begin
                cnt_ff <= 4'h0;
            end else if (m_i2c && ck_rise && cnt_ff != `DHI_I2C_END_CNT) begin
                sh_ff  <= {sh_ff[6:0], d_s[1]};
                cnt_ff <= cnt_ff + 4'h1;
            end else if (i2c_end) begin
                cnt_ff <= 4'h0;
            end
        end
    end

    // i2c frame walk: address, control byte, then data bytes
    always_ff @(posedge clk_sys_in) begin
        if (clr || !sel) begin
            i2c_ff      <= I2_IDLE;
            i2c_dc_ff   <= 1'b0;
            i2c_cont_ff <= 1'b0;
            ack_ff      <= 1'b0;
        end else if (ce_in) begin
            if (i2c_stop) begin
                i2c_ff <= I2_IDLE;
                ack_ff <= 1'b0;
            end else if (i2c_start) begin
                i2c_ff <= I2_ADDR;
                ack_ff <= 1'b0;
            end else if (i2c_byte) begin
                ack_ff <= i2c_ack;
                unique case (i2c_ff)
                    I2_IDLE: i2c_ff <= I2_IDLE;
                    I2_ADDR: i2c_ff <= addr_hit ? I2_CTRL : I2_SKIP;
                    I2_CTRL: begin
                        i2c_cont_ff <= sh_ff[`DHI_CTRL_CONT];
                        i2c_dc_ff   <= sh_ff[`DHI_CTRL_DC];
                        i2c_ff      <= I2_DATA;
                    end
                    I2_DATA: i2c_ff <= i2c_cont_ff ? I2_CTRL : I2_DATA;
                    I2_SKIP: i2c_ff <= I2_SKIP;
                endcase
            end else if (i2c_end) begin
                ack_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (clr) begin
            oe_ff     <= 8'h00;
            vd_ff     <= 8'h00;
            rd_stb_ff <= 1'b0;
        end else if (ce_in) begin
            oe_ff     <= nxt_oe;
            vd_ff     <= nxt_vd;
            rd_stb_ff <= rd_act && !oe_ff[7];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (clr) begin
            ovf_ff  <= 1'b0;
            init_ff <= 1'b1;
        end else if (ce_in) begin
            init_ff <= 1'b0;
            if (push_v && !fifo_ready && !m_i2c) begin
                ovf_ff <= 1'b1;
            end
        end
    end

    dhi_word_s in_w;
    dhi_word_s out_w;
    assign in_w = '{is_data: push_dc, data: push_b};

    dhi_fifo #(
        .WIDTH (`DHI_WORD_W),
        .DEPTH (`DHI_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in  (clk_sys_in),
        .clr_in      (clr),
        .ce_in       (ce_in),
        .s_valid_in  (push_v),
        .s_ready_out (fifo_ready),
        .s_data_in   (in_w),
        .m_valid_out (m_valid_out),
        .m_ready_in  (m_ready_in),
        .m_data_out  (out_w)
    );

    assign m_byte_out      = out_w.data;
    assign m_is_data_out   = out_w.is_data;
    assign pin.v_oe        = oe_ff;
    assign pin.v_d         = vd_ff;
    assign rd_strobe_out   = rd_stb_ff;
    assign init_active_out = init_ff;
    assign ovf_out         = ovf_ff;
endmodule
`default_nettype wire

/* hw/dhi_fifo.sv */
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "dhi_params.svh"
module dhi_fifo #(
    parameter int WIDTH = `DHI_WORD_W,
    parameter int DEPTH = `DHI_FIFO_DEPTH
) (
    input  wire logic             clk_sys_in,   // system clock
    input  wire logic             clr_in,       // synchronous flush
    input  wire logic             ce_in,        // clock enable
    input  wire logic             s_valid_in,   // write request
    output logic                  s_ready_out,  // not full
    input  wire logic [WIDTH-1:0] s_data_in,    // write word
    output logic                  m_valid_out,  // not empty
    input  wire logic             m_ready_in,   // read accept
    output logic [WIDTH-1:0]      m_data_out    // head word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wp_ff;
    logic [AW:0]      rp_ff;

    wire full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    wire empty = (wp_ff == rp_ff);
    wire do_wr = s_valid_in && !full;
    wire do_rd = m_ready_in && !empty;

    assign s_ready_out = !full;
    assign m_valid_out = !empty;
    assign m_data_out  = mem_ff[rp_ff[AW-1:0]];

    always_ff @(posedge clk_sys_in) begin
        if (clr_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else if (ce_in) begin
            if (do_wr) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (do_rd) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end

    // storage carries no reset: only pointer-qualified words are ever read
    always_ff @(posedge clk_sys_in) begin
        if (ce_in && do_wr && !clr_in) begin
            mem_ff[wp_ff[AW-1:0]] <= s_data_in;
        end
    end
endmodule
`default_nettype wire

/* hw/dhi_host.sv */
// display host port, host end: turns byte commands into pin sequences for the strapped style
`timescale 1ns/100ps
`default_nettype none
`include "dhi_params.svh"
module dhi_host
    import dhi_pkg::*;
#(
    parameter logic ADDR_LOW_BIT = 1'b0   // slave address low bit driven in i2c
) (
    input  wire logic       clk_sys_in,     // 40 MHz system clock
    input  wire logic       rst_in,         // synchronous reset, active high
    input  wire logic       ce_in,          // clock enable, freezes all state
    dhi_if.host             pin,            // device-facing pins
    input  wire logic [2:0] strap_sel_in,   // bus style, caught during reset
    input  wire logic       init_req_in,    // hold device settings at initial
    input  wire logic       cmd_valid_in,   // transfer request
    output logic            cmd_ready_out,  // idle, request taken
    input  wire logic       cmd_read_in,    // 1 read (parallel only)
    input  wire logic       cmd_is_data_in, // 1 display data, 0 command
    input  wire logic [7:0] cmd_byte_in,    // byte to write
    output logic            rd_valid_out,   // pulse: read byte ready
    output logic [7:0]      rd_byte_out,    // byte read
    output logic            nack_out        // i2c acknowledge missing in last transfer
);
    localparam logic [3:0] PH_LAST = 4'(`DHI_PHASE_CYC - 1);

    logic [7:0] b1_ff;
    logic [7:0] bus_s;
    always_ff @(posedge clk_sys_in) begin
        if (ce_in) begin
            b1_ff <= pin.bus;
            bus_s <= b1_ff;
        end
    end

    dhi_hstate_e st_ff;
    logic [3:0]  ph_ff;
    logic [4:0]  bc_ff;
    logic [4:0]  nb_ff;
    logic [26:0] sh_ff;
    logic        rd_ff;
    logic [2:0]  strap_ff;
    logic        cs_n_ff;
    logic        init_n_ff;
    logic        dc_ff;
    logic        wr_n_ff;
    logic        rd_n_ff;
    logic [7:0]  hd_ff;
    logic [7:0]  hoe_ff;
    logic        rdy_ff;
    logic        rdv_ff;
    logic [7:0]  rdb_ff;
    logic        nack_ff;

    wire dhi_mode_e mode = dhi_mode_of(strap_ff);
    wire ph_done  = (ph_ff == PH_LAST);
    wire take     = (st_ff == H_IDLE) && cmd_valid_in && rdy_ff;
    wire is_i2c   = (mode == MODE_I2C);
    wire is_ser   = (mode == MODE_SPI) || is_i2c;
    wire last_bit = (bc_ff == nb_ff - 5'd1);
    wire ack_slot = is_i2c && ((bc_ff == `DHI_ACK_POS_0) || (bc_ff == `DHI_ACK_POS_1)
                               || (bc_ff == `DHI_ACK_POS_2));
    wire [7:0] ctrl_b = 8'h00 | (8'h01 << `DHI_CTRL_DC) & {8{cmd_is_data_in}};
    wire [26:0] i2c_frame = {`DHI_I2C_ADDR_HI, ADDR_LOW_BIT, 1'b0, 1'b1,
                             ctrl_b, 1'b1, cmd_byte_in, 1'b1};

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            strap_ff <= strap_sel_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            init_n_ff <= 1'b0;
        end else if (ce_in) begin
            init_n_ff <= !init_req_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_ff   <= H_IDLE;
            ph_ff   <= 4'h0;
            bc_ff   <= 5'h00;
            nb_ff   <= 5'h00;
            sh_ff   <= 27'h0;
            rd_ff   <= 1'b0;
            cs_n_ff <= 1'b1;
            dc_ff   <= 1'b0;
            wr_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            hd_ff   <= 8'h00;
            hoe_ff  <= 8'h00;
            rdy_ff  <= 1'b1;
            rdv_ff  <= 1'b0;
            rdb_ff  <= 8'h00;
            nack_ff <= 1'b0;
        end else if (ce_in) begin
            rdv_ff <= 1'b0;
            ph_ff  <= (st_ff == H_IDLE || ph_done) ? 4'h0 : ph_ff + 4'h1;
            if (mode == MODE_ENA && st_ff == H_IDLE) begin
                rd_n_ff <= 1'b0;                   // enable idles low
            end
            unique case (st_ff)
                H_IDLE: if (take) begin
                    rdy_ff  <= 1'b0;
                    nack_ff <= 1'b0;
                    cs_n_ff <= 1'b0;
                    rd_ff   <= cmd_read_in && !is_ser;
                    dc_ff   <= is_i2c ? ADDR_LOW_BIT : cmd_is_data_in;
                    bc_ff   <= 5'h00;
                    nb_ff   <= is_i2c ? `DHI_I2C_BITS : `DHI_SPI_BITS;
                    sh_ff   <= is_i2c ? i2c_frame : {cmd_byte_in, 19'h0};
                    if (is_i2c) begin
                        hd_ff  <= 8'h01;           // clock high, data pulled low
                        hoe_ff <= 8'h03;
                        st_ff  <= H_START;
                    end else if (is_ser) begin
                        hd_ff  <= {6'h00, cmd_byte_in[7], 1'b0};
                        hoe_ff <= 8'h03;
                        st_ff  <= H_BLO;
                    end else begin
                        hd_ff   <= cmd_byte_in;
                        hoe_ff  <= cmd_read_in ? 8'h00 : 8'hff;
                        wr_n_ff <= (mode == MODE_ENA) ? cmd_read_in : 1'b1;
                        st_ff   <= H_SETUP;
                    end
                end
                H_SETUP: if (ph_done) begin
                    if (mode == MODE_ENA) begin
                        rd_n_ff <= 1'b1;
                    end else if (rd_ff) begin
                        rd_n_ff <= 1'b0;
                    end else begin
                        wr_n_ff <= 1'b0;
                    end
                    st_ff <= H_STRB;
                end
                H_STRB: if (ph_done) begin
                    if (rd_ff) begin
                        rdb_ff <= bus_s;
                        rdv_ff <= 1'b1;
                    end
                    rd_n_ff <= (mode == MODE_ENA) ? 1'b0 : 1'b1;
                    if (mode != MODE_ENA) begin
                        wr_n_ff <= 1'b1;
                    end
                    st_ff <= H_HOLD;
                end
                H_HOLD: if (ph_done) begin
                    hoe_ff  <= 8'h00;
                    cs_n_ff <= 1'b1;
                    wr_n_ff <= 1'b1;
                    st_ff   <= H_END;
                end
                H_START: if (ph_done) begin
                    hd_ff  <= 8'h00;
                    hoe_ff <= {6'h00, !sh_ff[26], 1'b1};
                    st_ff  <= H_BLO;
                end
                H_BLO: if (ph_done) begin
                    hd_ff[0] <= 1'b1;
                    st_ff    <= H_BHI;
                end
                H_BHI: if (ph_done) begin
                    if (ack_slot && bus_s[1]) begin
                        nack_ff <= 1'b1;
                    end
                    hd_ff[0] <= 1'b0;
                    sh_ff    <= {sh_ff[25:0], 1'b0};
                    bc_ff    <= bc_ff + 5'h01;
                    if (last_bit) begin
                        hoe_ff <= is_i2c ? 8'h03 : 8'h00;
                        hd_ff  <= 8'h00;
                        st_ff  <= is_i2c ? H_STOP1 : H_END;
                        cs_n_ff <= is_i2c ? 1'b0 : 1'b1;
                    end else if (is_i2c) begin
                        hoe_ff[1] <= !sh_ff[25];
                        st_ff     <= H_BLO;
                    end else begin
                        hd_ff[1] <= sh_ff[25];
                        st_ff    <= H_BLO;
                    end
                end
                H_STOP1: if (ph_done) begin
                    hd_ff[0] <= 1'b1;
                    st_ff    <= H_STOP2;
                end
                H_STOP2: if (ph_done) begin
                    hoe_ff[1] <= 1'b0;                 // data rises with clock high
                    st_ff     <= H_END;
                end
                H_END: if (ph_done) begin
                    hoe_ff  <= 8'h00;
                    cs_n_ff <= 1'b1;
                    rdy_ff  <= 1'b1;
                    st_ff   <= H_IDLE;
                end
            endcase
        end
    end

    assign pin.strap     = strap_ff;
    assign pin.cs_n      = cs_n_ff;
    assign pin.init_n    = init_n_ff;
    assign pin.dc        = dc_ff;
    assign pin.wr_n      = wr_n_ff;
    assign pin.rd_n      = rd_n_ff;
    assign pin.h_d       = hd_ff;
    assign pin.h_oe      = hoe_ff;
    assign cmd_ready_out = rdy_ff;
    assign rd_valid_out  = rdv_ff;
    assign rd_byte_out   = rdb_ff;
    assign nack_out      = nack_ff;
endmodule
`default_nettype wire

/* hw/dhi_if.sv */
// pin bundle between host and display device, with wired resolution of the data lines
`timescale 1ns/100ps
`default_nettype none
interface dhi_if;
    logic [2:0] strap;
    logic       cs_n;
    logic       init_n;
    logic       dc;
    logic       wr_n;
    logic       rd_n;
    logic [7:0] h_d;
    logic [7:0] h_oe;
    logic [7:0] v_d;
    logic [7:0] v_oe;
    logic [7:0] bus;

    // undriven lines float high (pull-up); two drivers resolve as wired-and
    assign bus = (h_d | ~h_oe) & (v_d | ~v_oe);

    modport device (
        input  strap, cs_n, init_n, dc, wr_n, rd_n, bus,
        output v_d, v_oe
    );
    modport host (
        output strap, cs_n, init_n, dc, wr_n, rd_n, h_d, h_oe,
        input  bus
    );
endinterface
`default_nettype wire

/* hw/dhi_params.svh */
// constants shared by both ends of the display host port
`ifndef DHI_PARAMS_SVH
`define DHI_PARAMS_SVH

// strap codes, ordered {strap_2, strap_1, strap_0}
`define DHI_STRAP_SEP   3'b110
`define DHI_STRAP_ENA   3'b100
`define DHI_STRAP_SPI4  3'b000
`define DHI_STRAP_SPI3  3'b001
`define DHI_STRAP_I2C   3'b010

// upper six bits of the seven-bit slave address; low bit comes from the pin
`define DHI_I2C_ADDR_HI 6'h1e
`define DHI_CTRL_CONT   7
`define DHI_CTRL_DC     6

`define DHI_WORD_W      9
`define DHI_FIFO_DEPTH  16

// link pacing: every host phase lasts at least this long
`define DHI_CLK_NS      25
`define DHI_PHASE_NS    200
`define DHI_PHASE_CYC   ((`DHI_PHASE_NS + `DHI_CLK_NS - 1) / `DHI_CLK_NS)

// bit counts and positions
`define DHI_SPI_LAST    4'd7
`define DHI_I2C_ACK_CNT 4'd8
`define DHI_I2C_END_CNT 4'd9
`define DHI_SPI_BITS    5'd8
`define DHI_I2C_BITS    5'd27
`define DHI_ACK_POS_0   5'd8
`define DHI_ACK_POS_1   5'd17
`define DHI_ACK_POS_2   5'd26

`endif

/* hw/dhi_pkg.sv */
// types shared by both ends of the display host port
`default_nettype none
`include "dhi_params.svh"
package dhi_pkg;

    typedef enum logic [2:0] {MODE_SEP, MODE_ENA, MODE_SPI, MODE_I2C, MODE_OFF} dhi_mode_e;

    typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_CTRL, I2_DATA, I2_SKIP} dhi_i2c_e;

    typedef enum logic [3:0] {
        H_IDLE, H_SETUP, H_STRB, H_HOLD, H_START, H_BLO, H_BHI, H_STOP1, H_STOP2, H_END
    } dhi_hstate_e;

    typedef struct packed {
        logic       is_data;
        logic [7:0] data;
    } dhi_word_s;

    // three-wire serial is carried like four-wire, with the select pin kept
    function automatic dhi_mode_e dhi_mode_of(input logic [2:0] strap);
        dhi_mode_e m;
        m = MODE_OFF;
        case (strap)
            `DHI_STRAP_SEP:  m = MODE_SEP;
            `DHI_STRAP_ENA:  m = MODE_ENA;
            `DHI_STRAP_SPI4: m = MODE_SPI;
            `DHI_STRAP_SPI3: m = MODE_SPI;
            `DHI_STRAP_I2C:  m = MODE_I2C;
            default:         m = MODE_OFF;
        endcase
        return m;
    endfunction

endpackage
`default_nettype wire

/* hw/dhi_unused_note.sv */
// intentionally empty compile unit kept out: none

/* test/dhi_pins_sva.sv */
// pin-level assertions on the display host port
`timescale 1ns/100ps
`default_nettype none
`include "dhi_params.svh"
module dhi_pins_sva (
    input wire logic       clk_sys_in, // clock
    input wire logic       rst_in,     // reset
    input wire logic [2:0] strap,      // style
    input wire logic       cs_n,       // select
    input wire logic       wr_n,       // write
    input wire logic       rd_n,       // read
    input wire logic [7:0] h_oe,       // host enables
    input wire logic [7:0] v_oe        // device enables
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // four cycles leave room for the device's pin synchronisers
    wire sep = strap == `DHI_STRAP_SEP;
    wire ena = strap == `DHI_STRAP_ENA;
    property p_desel; cs_n [*4] |-> v_oe == 8'h00; endproperty
    a_desel: assert property (p_desel) else $error("driven while deselected");
    property p_seprd; (sep && rd_n) [*4] |-> v_oe == 8'h00; endproperty
    a_seprd: assert property (p_seprd) else $error("driven without read");
    property p_ser; strap[2:1] == 2'b00 |-> v_oe[7:2] == 6'h00; endproperty
    a_ser: assert property (p_ser) else $error("serial upper lines driven");
    property p_i2c; strap == `DHI_STRAP_I2C |-> (v_oe & 8'hfd) == 8'h00; endproperty
    a_i2c: assert property (p_i2c) else $error("i2c line driven");
    property p_enawr; (ena && !wr_n) [*4] |-> v_oe == 8'h00; endproperty
    a_enawr: assert property (p_enawr) else $error("driven during write");
    property p_enaoff; (ena && !rd_n) [*4] |-> v_oe == 8'h00; endproperty
    a_enaoff: assert property (p_enaoff) else $error("driven while disabled");
    property p_hcs; sep && h_oe != 8'h00 |-> !cs_n; endproperty
    a_hcs: assert property (p_hcs) else $error("host drives unselected");
    property p_strap; !$past(rst_in) |-> $stable(strap); endproperty
    a_strap: assert property (p_strap) else $error("strap moved");
    c_wr: cover property (sep && !wr_n);
    c_rd: cover property (v_oe == 8'hff);
    c_ack: cover property (v_oe[1] && strap == `DHI_STRAP_I2C);
endmodule
`default_nettype wire

/* test/display_host_interface_pins_tb.sv */
// bench: host end drives device end in each strapped style except three-wire serial
`timescale 1ns/100ps
`default_nettype none
`include "dhi_params.svh"
module display_host_interface_pins_tb;
    logic       clk_sys_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       ce_in = 1'b1;
    logic [2:0] strap_sel_in = `DHI_STRAP_SEP;
    logic       init_req_in = 1'b0, cmd_valid_in = 1'b0, cmd_read_in = 1'b0;
    logic       cmd_is_data_in = 1'b0, m_ready_in = 1'b0;
    logic [7:0] cmd_byte_in = 8'h00, rd_byte_in = 8'h00, rd_byte_out, m_byte_out;
    logic       cmd_ready_out, rd_valid_out, nack_out, rd_strobe_out, m_valid_out;
    logic       m_is_data_out, init_active_out, ovf_out;
    int         n_mismatch = 0, checks = 0;
    int         n_rd_stb = 0, n_rd_vld = 0;
    // read pulses are counted at the falling edge, where they are settled
    always @(negedge clk_sys_in) begin
        n_rd_stb += int'(rd_strobe_out === 1'b1);
        n_rd_vld += int'(rd_valid_out === 1'b1);
    end
    dhi_if pin ();
    dhi_host dhi_host_i (.*);
    dhi_device dhi_device_i (.*);
    dhi_pins_sva dhi_pins_sva_i (.clk_sys_in, .rst_in, .strap(pin.strap), .cs_n(pin.cs_n),
        .wr_n(pin.wr_n), .rd_n(pin.rd_n), .h_oe(pin.h_oe), .v_oe(pin.v_oe));
    always #12.5 clk_sys_in = ~clk_sys_in;
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic restart(input logic [2:0] s);
        rst_in = 1'b1;
        strap_sel_in = s;
        repeat (20) @(negedge clk_sys_in);
        rst_in = 1'b0;
        repeat (6) @(negedge clk_sys_in);
    endtask
    // one whole command; the wait for ready is bounded
    task automatic xfer(input logic rd, input logic dc, input logic [7:0] b);
        int i;
        {cmd_read_in, cmd_is_data_in, cmd_byte_in, cmd_valid_in} = {rd, dc, b, 1'b1};
        @(negedge clk_sys_in);
        cmd_valid_in = 1'b0;
        for (i = 0; i < 2000 && cmd_ready_out !== 1'b1; i++) @(negedge clk_sys_in);
        if (i == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
        repeat (2) @(negedge clk_sys_in);
    endtask
    task automatic pop(input logic [8:0] exp);
        chk(m_valid_out, 9'h001);
        chk({m_is_data_out, m_byte_out}, exp);
        m_ready_in = 1'b1;
        @(negedge clk_sys_in);
        m_ready_in = 1'b0;
    endtask
    task automatic t_sep();
        restart(`DHI_STRAP_SEP);
        rd_byte_in = 8'h5a;
        xfer(1'b0, 1'b0, 8'h3c);
        xfer(1'b0, 1'b1, 8'ha5);
        pop(9'h03c);
        pop(9'h1a5);
        xfer(1'b1, 1'b0, 8'h00);
        chk(rd_byte_out, 9'h05a);
        chk(9'(n_rd_stb), 9'h001);
        chk(9'(n_rd_vld), 9'h001);
        for (int k = 0; k < 17; k++) xfer(1'b0, 1'b1, 8'(k));
        chk(ovf_out, 9'h001);
        for (int k = 0; k < 16; k++) pop({1'b1, 8'(k)});
        chk(m_valid_out, 9'h000);
    endtask
    task automatic t_ena();
        restart(`DHI_STRAP_ENA);
        rd_byte_in = 8'hc3;
        xfer(1'b0, 1'b0, 8'h81);
        pop(9'h081);
        xfer(1'b1, 1'b1, 8'h00);
        chk(rd_byte_out, 9'h0c3);
        chk(9'(n_rd_stb), 9'h002);
        chk(9'(n_rd_vld), 9'h002);
    endtask
    task automatic t_ser();
        restart(`DHI_STRAP_SPI4);
        xfer(1'b0, 1'b1, 8'h96);
        pop(9'h196);
    endtask
    task automatic t_i2c();
        restart(`DHI_STRAP_I2C);
        xfer(1'b0, 1'b0, 8'h69);
        pop(9'h069);
        chk(nack_out, 9'h000);
    endtask
    task automatic t_init();
        xfer(1'b0, 1'b1, 8'h11);
        chk(m_valid_out, 9'h001);
        init_req_in = 1'b1;
        repeat (8) @(negedge clk_sys_in);
        chk(init_active_out, 9'h001);
        chk(m_valid_out, 9'h000);
        init_req_in = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        chk(init_active_out, 9'h000);
    endtask
    initial begin
        t_sep();
        t_ena();
        t_ser();
        t_i2c();
        t_init();
        report_and_stop();
    end
endmodule
`default_nettype wire
